// >>> hdl/pcb_consts.vh
/*
 Constants of the counter array time base: register offsets, field positions,
 reset values and divider counts.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef PCB_CONSTS_VH
`define PCB_CONSTS_VH

// ==========================================================
// Register word indices (APB byte address is four times the index)
`define PCB_IDX_MODE 10'h0D9
`define PCB_IDX_CONTROL 10'h0D8
`define PCB_IDX_COUNT 10'h0E9
`define PCB_IDX_IRQ_STATUS 10'h100
`define PCB_IDX_IRQ_MASK 10'h104
`define PCB_IDX_MODULE_BASE 10'h110

// ==========================================================
// Module register fields
`define PCB_MREG_MODE_HI 18
`define PCB_MREG_MODE_LO 16
`define PCB_MREG_IRQ_EN 19
`define PCB_MREG_FLAG_CLR 20

// ==========================================================
// Mode register fields
`define PCB_MODE_IDLE_GATE 7
`define PCB_MODE_WDOG_EN 6
`define PCB_MODE_SEL_HI 2
`define PCB_MODE_SEL_LO 1
`define PCB_MODE_OVF_IRQ_EN 0
`define PCB_MODE_RESET 8'h00
`define PCB_MODE_WMASK 8'hC7

// ==========================================================
// Control register fields
`define PCB_CTRL_OVF_FLAG 7
`define PCB_CTRL_RUN 6

// ==========================================================
// Count source codes
`define PCB_SRC_DIV_SLOW 2'h0
`define PCB_SRC_DIV_FAST 2'h1
`define PCB_SRC_TIMER 2'h2
`define PCB_SRC_EXT 2'h3

// ==========================================================
// Prescaler divides
`define PCB_DIV_SLOW 8'h0C
`define PCB_DIV_FAST 8'h04
`define PCB_DIV_SLOW_X2 8'h06
`define PCB_DIV_FAST_X2 8'h02

// ==========================================================
// Module mode codes
`define PCB_MOD_OFF 3'h0
`define PCB_MOD_CAP_RISE 3'h1
`define PCB_MOD_CAP_FALL 3'h2
`define PCB_MOD_CAP_BOTH 3'h3
`define PCB_MOD_SWTIMER 3'h4
`define PCB_MOD_HSO 3'h5
`define PCB_MOD_PWM 3'h6

`endif

// >>> hdl/pcb_module_bank.v
/*
 Storage of the five module compare values as a small memory.
 Assumes single write port and registered read data on the system clock.
*/
module pcb_module_bank
#(
	parameter DEPTH = 5,
	parameter AW = 3
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Write port
	input wire wrEn,
	input wire [AW-1:0] wrAddr,
	input wire [15:0] wrData,
	// Read port
	input wire [AW-1:0] rdAddr,
	output reg [15:0] rdData_q
);

	reg [15:0] mem [0:DEPTH-1];
	integer i;

	// ==========================================================
	// Write and registered read
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdData_q <= 16'h0000;
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= 16'h0000;
		end
		else
		begin
			if (wrEn)
				mem[wrAddr] <= wrData;
			rdData_q <= mem[rdAddr];
		end
	end

endmodule

// >>> hdl/pcb_time_base.v
/*
 Time base and mode control of the counter array: 16-bit shared counter,
 count source selection, idle gating, watchdog enable, simple per-module
 compare/capture with pin outputs, merged interrupt, APB register access.
 Assumes the external count pin and module pins are asynchronous, the
 timer overflow pulse and idle/double-speed levels come from clk_sys logic.
*/
// Functional notes
// R1 - One 16-bit counter is the common time base of five modules.
// R2 - The source select picks osc/12, osc/4, timer overflow or the external pin.
// R3 - With double speed the two internal sources divide by 6 and 2.
// R4 - An external source must count no faster than one eighth of the oscillator.
// R5 - The watchdog enable bit turns the watchdog duty of module 4 off or on.
// R6 - Each module can capture on rising, falling or both edges, time, toggle or modulate.
// R7 - Capture, software timer and toggle modes can raise a request on their event.
// R8 - All five module requests and overflow merge onto one interrupt line.
// R9 - The count pin is port-1 bit 2 and modules use bits 3 to 7; other pins stay I/O.
// R10 - Mode register bits 5 to 3 are unimplemented and read as zero.
// R11 - With the idle gate set the counter halts while the processor idles.
// R12 - The overflow enable bit lets the overflow flag request an interrupt.
// R13 - The counter steps by one per source pulse, wraps to zero and flags overflow.
`include "pcb_consts.vh"
module pcb_time_base
#(
	parameter NMOD = 5
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// System status
	input wire cpuIdle,
	input wire doubleSpeed,
	input wire timerOverflow,
	// Port-1 pins
	input wire [7:0] port1In,
	input wire [7:0] port1SwOut,
	input wire [7:0] port1SwOe,
	output wire [7:0] port1Out,
	output wire [7:0] port1Oe,
	// Module 4 watchdog and merged interrupt
	output wire watchdogReset,
	output wire irq
);

	// ==========================================================
	// Registers
	reg [7:0] modeReg_q;
	reg runEn_q;
	reg ovfFlag_q;
	reg [15:0] count_q;
	reg [7:0] prescale_q;
	reg [NMOD-1:0] modFlag_q;
	reg [NMOD-1:0] modIrqEn_q;
	reg [NMOD-1:0] modOut_q;
	reg [2:0] modMode_q [0:NMOD-1];
	reg [15:0] capVal_q [0:NMOD-1];
	reg [5:0] irqStatus_q;
	reg [5:0] irqMask_q;
	reg [5:0] evtPrev_q;
	reg [7:0] pinMeta_q;
	reg [7:0] pinSync_q;
	reg [7:0] pinPrev_q;
	reg [2:0] syncFill_q;
	reg wdogHit_q;
	integer k;
	integer j;
	integer c;

	// ==========================================================
	// Helpers
	function [7:0] divFor;
		input [1:0] sel;
		input x2;
		begin
			if (sel == `PCB_SRC_DIV_SLOW)
				divFor = x2 ? `PCB_DIV_SLOW_X2 : `PCB_DIV_SLOW;
			else
				divFor = x2 ? `PCB_DIV_FAST_X2 : `PCB_DIV_FAST;
		end
	endfunction

	function isCaptureMode;
		input [2:0] m;
		begin
			isCaptureMode = (m == `PCB_MOD_CAP_RISE) || (m == `PCB_MOD_CAP_FALL)
				|| (m == `PCB_MOD_CAP_BOTH);
		end
	endfunction

	// ==========================================================
	// APB decode
	wire apbWrite = psel & penable & pwrite;
	wire apbRead = psel & penable & ~pwrite;
	wire [9:0] regIdx = paddr[11:2];
	wire wordAligned = (paddr[1:0] == 2'h0);
	wire selMode = wordAligned && (regIdx == `PCB_IDX_MODE);
	wire selCtrl = wordAligned && (regIdx == `PCB_IDX_CONTROL);
	wire selCount = wordAligned && (regIdx == `PCB_IDX_COUNT);
	wire selStat = wordAligned && (regIdx == `PCB_IDX_IRQ_STATUS);
	wire selMask = wordAligned && (regIdx == `PCB_IDX_IRQ_MASK);
	wire [9:0] modOfs = regIdx - `PCB_IDX_MODULE_BASE;
	wire selModule = wordAligned && (regIdx >= `PCB_IDX_MODULE_BASE)
		&& (modOfs < NMOD);
	wire [2:0] modSel = modOfs[2:0];
	wire mapped = selMode | selCtrl | selCount | selStat | selMask | selModule;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ==========================================================
	// Pin synchronisers
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pinMeta_q <= 8'h00;
			pinSync_q <= 8'h00;
			pinPrev_q <= 8'h00;
			syncFill_q <= 3'h0;
		end
		else
		begin
			pinMeta_q <= port1In;
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
			syncFill_q <= {syncFill_q[1:0], 1'b1};
		end
	end

	// Edges blanked until the chain holds real pin levels (no false edge after reset)
	wire [7:0] pinRise = pinSync_q & ~pinPrev_q & {8{syncFill_q[2]}};
	wire [7:0] pinFall = ~pinSync_q & pinPrev_q & {8{syncFill_q[2]}};

	// ==========================================================
	// Count pulse selection
	wire [1:0] srcSel = {modeReg_q[`PCB_MODE_SEL_HI], modeReg_q[`PCB_MODE_SEL_LO]};
	wire internalSrc = (srcSel == `PCB_SRC_DIV_SLOW) || (srcSel == `PCB_SRC_DIV_FAST);
	wire prescaleEnd = (prescale_q >= divFor(srcSel, doubleSpeed) - 8'h01); // R3
	wire idleHold = modeReg_q[`PCB_MODE_IDLE_GATE] & cpuIdle; // R11
	wire counting = runEn_q & ~idleHold;
	reg srcPulse;

	// Source multiplexer
	always @*
	begin
		case (srcSel) // R2
			`PCB_SRC_DIV_SLOW: srcPulse = prescaleEnd;
			`PCB_SRC_DIV_FAST: srcPulse = prescaleEnd;
			`PCB_SRC_TIMER: srcPulse = timerOverflow;
			`PCB_SRC_EXT: srcPulse = pinRise[2]; // R9
			default: srcPulse = 1'b0;
		endcase
	end

	wire countStep = counting & srcPulse;
	wire wrap = countStep & (count_q == 16'hFFFF);

	// Prescaler
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			prescale_q <= 8'h00;
		else if (!counting || !internalSrc || prescaleEnd)
			prescale_q <= 8'h00;
		else
			prescale_q <= prescale_q + 8'h01;
	end

	// ==========================================================
	// Counter, mode and control
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			count_q <= 16'h0000;
			modeReg_q <= `PCB_MODE_RESET;
			runEn_q <= 1'b0;
			ovfFlag_q <= 1'b0;
		end
		else
		begin
			if (apbWrite && selCount)
				count_q <= pwdata[15:0];
			else if (countStep)
				count_q <= count_q + 16'h0001; // R1 R13
			if (apbWrite && selMode)
				modeReg_q <= pwdata[7:0] & `PCB_MODE_WMASK; // R10
			if (apbWrite && selCtrl)
				runEn_q <= pwdata[`PCB_CTRL_RUN];
			if (wrap)
				ovfFlag_q <= 1'b1; // R13
			else if (apbWrite && selCtrl && !pwdata[`PCB_CTRL_OVF_FLAG])
				ovfFlag_q <= 1'b0;
		end
	end

	// ==========================================================
	// Modules
	wire [NMOD-1:0] modEvent;
	genvar g;
	generate
		for (g = 0; g < NMOD; g = g + 1)
		begin : gMod
			wire [2:0] md = modMode_q[g];
			wire capHit = (md == `PCB_MOD_CAP_RISE && pinRise[g+3])
				|| (md == `PCB_MOD_CAP_FALL && pinFall[g+3])
				|| (md == `PCB_MOD_CAP_BOTH && (pinRise[g+3] | pinFall[g+3]));
			wire cmpHit = countStep && (count_q == capVal_q[g])
				&& (md == `PCB_MOD_SWTIMER || md == `PCB_MOD_HSO);
			assign modEvent[g] = capHit | cmpHit; // R6 R7
		end
	endgenerate

	// Module state
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			modFlag_q <= {NMOD{1'b0}};
			modIrqEn_q <= {NMOD{1'b0}};
			modOut_q <= {NMOD{1'b0}};
			for (k = 0; k < NMOD; k = k + 1)
			begin
				modMode_q[k] <= `PCB_MOD_OFF;
				capVal_q[k] <= 16'h0000;
			end
		end
		else
		begin
			for (k = 0; k < NMOD; k = k + 1)
			begin
				if (apbWrite && selModule && modSel == k)
				begin
					modMode_q[k] <= pwdata[`PCB_MREG_MODE_HI:`PCB_MREG_MODE_LO];
					modIrqEn_q[k] <= pwdata[`PCB_MREG_IRQ_EN];
					capVal_q[k] <= pwdata[15:0];
				end
				else if (modEvent[k] && isCaptureMode(modMode_q[k]))
					capVal_q[k] <= count_q;
				if (modEvent[k])
					modFlag_q[k] <= 1'b1;
				else if (apbWrite && selModule && modSel == k && pwdata[`PCB_MREG_FLAG_CLR])
					modFlag_q[k] <= 1'b0;
				if (modEvent[k] && modMode_q[k] == `PCB_MOD_HSO)
					modOut_q[k] <= ~modOut_q[k];
				else if (modMode_q[k] == `PCB_MOD_PWM)
					modOut_q[k] <= (count_q[7:0] >= capVal_q[k][7:0]);
			end
		end
	end

	// Watchdog on module 4
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			wdogHit_q <= 1'b0;
		else
			wdogHit_q <= modeReg_q[`PCB_MODE_WDOG_EN] & modEvent[4]
				& (modMode_q[4] == `PCB_MOD_SWTIMER); // R5
	end

	assign watchdogReset = wdogHit_q;

	// ==========================================================
	// Module value store: APB write wins, else lowest capturing module
	wire modWrite = apbWrite & selModule;
	wire [15:0] bankRd;
	reg capAny;
	reg [2:0] capIdx;

	// A second capture in one cycle reaches its compare register only
	always @*
	begin
		capAny = 1'b0;
		capIdx = 3'h0;
		for (c = NMOD - 1; c >= 0; c = c - 1)
		begin
			if (modEvent[c] && isCaptureMode(modMode_q[c]))
			begin
				capAny = 1'b1;
				capIdx = c[2:0];
			end
		end
	end

	// Read address taken in the setup cycle, data stands in the access cycle
	pcb_module_bank #(.DEPTH(NMOD), .AW(3)) pcb_module_bank_inst (
		.clk_sys(clk_sys), .rst(rst), .wrEn(modWrite | capAny),
		.wrAddr(modWrite ? modSel : capIdx), .wrData(modWrite ? pwdata[15:0] : count_q),
		.rdAddr(selModule ? modSel : 3'h0), .rdData_q(bankRd));

	// ==========================================================
	// Pins: bit 2 left to software like bits 1..0, bits 3..7 driven by modules in toggle or PWM mode
	reg [7:0] pinOwn;
	always @*
	begin
		pinOwn = 8'h00;
		for (j = 0; j < NMOD; j = j + 1)
			pinOwn[j+3] = (modMode_q[j] == `PCB_MOD_HSO) || (modMode_q[j] == `PCB_MOD_PWM);
	end

	assign port1Out = (pinOwn & {modOut_q, 3'h0}) | (~pinOwn & port1SwOut); // R9
	assign port1Oe = pinOwn | port1SwOe;

	// ==========================================================
	// Interrupts: bit 5 overflow, bits 4..0 modules
	wire [5:0] evtLevel = {ovfFlag_q & modeReg_q[`PCB_MODE_OVF_IRQ_EN], // R12
		modFlag_q & modIrqEn_q};
	wire [5:0] evtSet = evtLevel & ~evtPrev_q;
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			irqStatus_q <= 6'h00;
			irqMask_q <= 6'h00;
			evtPrev_q <= 6'h00;
		end
		else
		begin
			evtPrev_q <= evtLevel;
			if (apbWrite && selStat)
				irqStatus_q <= (irqStatus_q & ~pwdata[5:0]) | evtSet;
			else
				irqStatus_q <= irqStatus_q | evtSet;
			if (apbWrite && selMask)
				irqMask_q <= pwdata[5:0];
		end
	end

	assign irq = |(irqStatus_q & irqMask_q); // R8

	// ==========================================================
	// Read mux
	always @*
	begin
		prdata = 32'h0000_0000;
		if (apbRead)
		begin
			if (selMode)
				prdata = {24'h0, modeReg_q & `PCB_MODE_WMASK};
			else if (selCtrl)
				prdata = {24'h0, ovfFlag_q, runEn_q, 1'b0, modFlag_q};
			else if (selCount)
				prdata = {16'h0, count_q};
			else if (selStat)
				prdata = {26'h0, irqStatus_q};
			else if (selMask)
				prdata = {26'h0, irqMask_q};
			else if (selModule)
				prdata = {11'h0, modFlag_q[modSel], modIrqEn_q[modSel],
					modMode_q[modSel], bankRd};
		end
	end

endmodule

// >>> sim/pcb_pin_model.sv
/* Pin model: external count pulses on port-1 bit 2, idle module pins.
 Assumes a one-cycle start request from the bench. */
module pcb_pin_model (
	// Clock and request
	input logic clk_sys,
	input logic start,
	input logic [3:0] pulses,
	// Port-1 pins
	output logic [7:0] port1In
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left_q = 4'h0;
	logic [2:0] ph_q = 3'h0;
	// Pulse train, eight cycles per pulse
	always @(posedge clk_sys)
		if (start)
		begin
			left_q <= pulses;
			ph_q <= 3'h0;
		end
		else if (left_q != 4'h0)
		begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7)
				left_q <= left_q - 4'h1;
		end
	// Count pin high half a period; pulled-up pins elsewhere
	assign port1In = {5'h1F, left_q != 4'h0 && !ph_q[2], 2'h3};
endmodule

// >>> sim/pcb_time_base_monitor.sv
/* Port checker of the counter array time base.
 Assumes binding into pcb_time_base. */
module pcb_time_base_monitor (
	// Clock and reset
	input logic clk_sys,
	input logic rst,
	// APB
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// Pins and events
	input logic [7:0] port1SwOut,
	input logic [7:0] port1SwOe,
	input logic [7:0] port1Out,
	input logic [7:0] port1Oe,
	input logic watchdogReset,
	input logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic wdEn_q;
	logic [5:0] mask_q;
	wire rdAcc = psel && penable && !pwrite;
	wire wrDone = psel && penable && pwrite && pready;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// Mirror of watchdog enable and interrupt mask
	always @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			wdEn_q <= 1'b0;
			mask_q <= 6'h00;
		end
		else if (wrDone && paddr == 12'h364)
			wdEn_q <= pwdata[6];
		else if (wrDone && paddr == 12'h410)
			mask_q <= pwdata[5:0];
	// ==========================================================
	// Properties
	property p_ready; psel && penable |-> pready; endproperty
	property p_err_phase; pslverr |-> psel && penable; endproperty
	property p_unmapped; rdAcc && pslverr |-> prdata == 32'h0; endproperty
	property p_mode_rsvd;
		rdAcc && paddr == 12'h364 |-> prdata[31:8] == 24'h0 && prdata[5:3] == 3'h0;
	endproperty
	property p_sw_pins;
		port1Out[1:0] == port1SwOut[1:0] && port1Oe[1:0] == port1SwOe[1:0];
	endproperty
	property p_wd_pulse; $rose(watchdogReset) |=> !watchdogReset; endproperty
	property p_wd_en; watchdogReset |-> $past(wdEn_q); endproperty
	property p_irq_mask; (mask_q == 6'h00) [*2] |-> !irq; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode bits set");
	a_sw_pins: assert property (p_sw_pins) else $error("free pins not software driven");
	a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog pulse too long");
	a_wd_en: assert property (p_wd_en) else $error("watchdog pulse while disabled");
	a_irq_mask: assert property (p_irq_mask) else $error("irq with mask clear");
	c_irq: cover property ($rose(irq));
	c_wd: cover property (watchdogReset);
	c_err: cover property (pslverr);
endmodule
bind pcb_time_base pcb_time_base_monitor pcb_time_base_monitor_inst (.clk_sys(clk_sys),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port1SwOut(port1SwOut), .port1SwOe(port1SwOe), .port1Out(port1Out),
	.port1Oe(port1Oe), .watchdogReset(watchdogReset), .irq(irq));

// >>> sim/tb_pcb_time_base.sv
/* Testbench of the counter array time base over APB.
 Assumes the pin model and the bound port checker. */
module tb_pcb_time_base;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, cpuIdle = 0, doubleSpeed = 0, timerOverflow = 0;
	logic [7:0] port1In, port1SwOut = 8'hA5, port1SwOe = 8'h03, port1Out, port1Oe;
	logic watchdogReset, irq, pStart = 0;
	int err_total = 0, checks_done = 0, wdHits = 0, divs[4] = '{12, 4, 6, 2};
	// 10 MHz clock
	always #50 clk_sys = ~clk_sys;
	pcb_time_base pcb_time_base_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle), .doubleSpeed(doubleSpeed),
		.timerOverflow(timerOverflow), .port1In(port1In), .port1SwOut(port1SwOut),
		.port1SwOe(port1SwOe), .port1Out(port1Out), .port1Oe(port1Oe),
		.watchdogReset(watchdogReset), .irq(irq));
	pcb_pin_model pcb_pin_model_inst (.clk_sys(clk_sys), .start(pStart), .pulses(4'h5),
		.port1In(port1In));
	// Count watchdog pulses
	always @(posedge clk_sys)
		if (watchdogReset === 1'b1)
			wdHits++;
	// ==========================================================
	// Tasks
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol);
		checks_done++;
		if (^g === 1'bx || g > e + tol || g + tol < e)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Level outputs looked at mid-cycle, then back on the rising edge
	task automatic chkIrq(input logic e);
		@(negedge clk_sys);
		chk({31'h0, irq}, {31'h0, e}, 0);
		@(posedge clk_sys);
	endtask
	task automatic chkPins(input logic [7:0] eo, input logic [7:0] ee);
		@(negedge clk_sys);
		chk({24'h0, port1Out}, {24'h0, eo}, 0);
		chk({24'h0, port1Oe}, {24'h0, ee}, 0);
		@(posedge clk_sys);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_total++;
			wrap_up();
		end
		else
			@(posedge clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e, 0);
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			timerOverflow <= 1'b1;
			@(posedge clk_sys);
			timerOverflow <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rdc(12'h364, 32'h0, 32'hFF);
		rdc(12'h3A4, 32'h0, 32'hFFFF);
		wr(12'h364, 32'hFF);
		rdc(12'h364, 32'hC7, 32'hFF);
		apb(1'b0, 12'h0F0, 32'h0);
		chk({31'h0, err}, 32'h1, 0);
		for (int i = 0; i < 4; i++)
		begin
			doubleSpeed <= i[1];
			wr(12'h364, {30'h0, i[0], 1'b0});
			wr(12'h3A4, 32'h0);
			wr(12'h360, 32'h40);
			repeat (117) @(posedge clk_sys);
			wr(12'h360, 32'h0);
			apb(1'b0, 12'h3A4, 32'h0);
			chk(rd, 120 / divs[i], 1);
		end
		doubleSpeed <= 1'b0;
		wr(12'h364, 32'h04);
		wr(12'h3A4, 32'h0);
		wr(12'h360, 32'h40);
		tick(7);
		rdc(12'h3A4, 32'h7, 32'hFFFF);
		wr(12'h364, 32'h06);
		wr(12'h3A4, 32'h0);
		pStart <= 1'b1;
		@(posedge clk_sys);
		pStart <= 1'b0;
		repeat (50) @(posedge clk_sys);
		rdc(12'h3A4, 32'h5, 32'hFFFF);
		wr(12'h364, 32'h84);
		wr(12'h3A4, 32'h0);
		cpuIdle <= 1'b1;
		tick(3);
		rdc(12'h3A4, 32'h0, 32'hFFFF);
		wr(12'h364, 32'h04);
		tick(2);
		rdc(12'h3A4, 32'h2, 32'hFFFF);
		cpuIdle <= 1'b0;
		wr(12'h450, 32'h0004_0003);
		wr(12'h364, 32'h44);
		wr(12'h3A4, 32'h0);
		tick(5);
		chk(wdHits, 1, 0);
		wr(12'h364, 32'h04);
		wr(12'h3A4, 32'h0);
		tick(5);
		chk(wdHits, 1, 0);
		wr(12'h410, 32'h20);
		wr(12'h364, 32'h05);
		wr(12'h3A4, 32'hFFFF);
		chkIrq(1'b0);
		tick(1);
		rdc(12'h3A4, 32'h0, 32'hFFFF);
		rdc(12'h360, 32'h80, 32'h80);
		rdc(12'h400, 32'h20, 32'h20);
		chkIrq(1'b1);
		wr(12'h410, 32'h0);
		chkIrq(1'b0);
		wr(12'h410, 32'h20);
		wr(12'h400, 32'h3F);
		chkIrq(1'b0);
		// Module 0 toggles its pin on match, module 1 modulates
		wr(12'h440, 32'h0005_0002);
		rdc(12'h440, 32'h0005_0002, 32'h001F_FFFF);
		wr(12'h3A4, 32'h0);
		chkPins(8'hA5, 8'h0B);
		tick(3);
		chkPins(8'hAD, 8'h0B);
		rdc(12'h440, 32'h0015_0002, 32'h001F_FFFF);
		wr(12'h444, 32'h0006_0010);
		wr(12'h3A4, 32'h20);
		chkPins(8'hBD, 8'h1B);
		wrap_up();
	end
endmodule
